// >>> hdl/adcc_top.sv
// Converter control registers, input selector drive and conversion sequencer
//
// Summary of operation
// - One converter; channel switch follows the channel field whatever the source
// - Two 8-bit control registers hold everything
// - Channel field picks external analog channel
// - Source field picks internal or external
// - Analog-selected pin loses its digital function
// - Analog-selected pin loses its pull-up
// - Source 000 routes selected external channel
// - Sources 101 to 111 act like 000
// - Source 001 connects bandgap voltage
// - Sources 010, 011 connect op-amp output
// - Source 100 connects negative supply rail
// - Reference 00, 10, 11 uses external pin
// - Reference 01 uses internal positive supply
// - Divider codes 000-011 give 1,2,4,8
// - Divider codes 100-111 give 16..128
// - Start bit low-high-low begins conversion
// - Busy set on start, cleared on completion
// - Converter powered only while enable high
// - Format bit selects result byte alignment
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
module adcc_top
  import adcc_pkg::*;
#(
  parameter int CONV_CLOCKS = ADCC_CONV_CLOCKS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [11:0] result_in,
  input wire logic [ADCC_NUM_CH-1:0] pin_analog_sel,
  output adcc_mux_t mux_ctrl,
  output logic conv_power,
  output logic conv_clk_en,
  output logic conv_active,
  output logic [ADCC_NUM_CH-1:0] pin_digital_off,
  output logic [ADCC_NUM_CH-1:0] pin_pullup_off,
  output logic align_sel,
  output logic [7:0] result_high,
  output logic [7:0] result_low,
  output logic conv_done_evt
);

  localparam int CNT_W = $clog2(CONV_CLOCKS);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CLOCKS - 1);

  // Divider terminal count for a code: 2**code - 1
  function automatic logic [6:0] div_last(input logic [2:0] code);
    logic [7:0] span;
    span = 8'h01 << code;
    div_last = 7'(span - 8'h01);
  endfunction : div_last

  adcc_ctrl_a_t ctrl_a; // Control register A
  adcc_ctrl_b_t ctrl_b; // Control register B
  adcc_ctrl_a_t next_ctrl_a;
  adcc_ctrl_b_t next_ctrl_b;
  adcc_state_t state; // Sequencer state
  adcc_state_t next_state;
  logic [CNT_W-1:0] conv_cnt; // Conversion ticks elapsed
  logic [6:0] div_cnt; // Conversion clock divider
  logic [11:0] result; // Last completed result
  logic [11:0] res_meta; // First synchroniser stage
  logic [11:0] res_sync; // Second synchroniser stage
  logic wr_pend; // Write data phase pending
  logic [7:0] addr_q; // Address captured in address phase
  adcc_mux_t next_mux;

  // Bus decode
  wire addr_valid = hsel & htrans[1] & hready;
  wire rd_take = addr_valid & ~hwrite;
  wire wr_a = wr_pend & (addr_q == ADCC_OFF_CTRL_A);
  wire wr_b = wr_pend & (addr_q == ADCC_OFF_CTRL_B);
  wire [7:0] wbyte = hwdata[7:0];

  // Start sequence: a write taking start from high to low while powered
  wire next_power = wr_a ? wbyte[ADCC_A_POWER_BIT] : ctrl_a.power;
  wire in_conv = (state == ADCC_CONV);
  // A start written while busy is ignored and must not restart the counters
  wire start_kick = wr_a & ctrl_a.start & ~wbyte[ADCC_A_START_BIT] & next_power &
                    ~in_conv;

  // Divider tick at the selected rate
  wire conv_tick = (div_cnt == div_last(ctrl_b.div));
  wire conv_end = in_conv & next_power & conv_tick & (conv_cnt == CONV_LAST);
  wire [6:0] next_div_cnt = (start_kick | conv_tick | ~next_power) ? 7'h00 : div_cnt + 7'h01;
  wire next_tick = (next_div_cnt == div_last(next_ctrl_b.div));

  // Result captured on completion, else held even when disabled
  wire [11:0] next_result = conv_end ? res_sync : result;
  wire next_align = wr_a ? wbyte[ADCC_A_ALIGN_BIT] : ctrl_a.align;
  wire [7:0] next_res_hi = next_align ? {4'h0, next_result[11:8]} : next_result[11:4];
  wire [7:0] next_res_lo = next_align ? next_result[7:0] : {next_result[3:0], 4'h0};

  // Next value of control register A; busy follows the sequencer
  always_comb begin
    next_ctrl_a = ctrl_a;
    if (wr_a) begin
      next_ctrl_a.start = wbyte[ADCC_A_START_BIT];
      next_ctrl_a.power = wbyte[ADCC_A_POWER_BIT];
      next_ctrl_a.align = wbyte[ADCC_A_ALIGN_BIT];
      next_ctrl_a.ch = wbyte[ADCC_A_CH_LSB +: 4];
    end
    next_ctrl_a.busy = (next_state == ADCC_CONV);
  end

  // Next value of control register B
  always_comb begin
    next_ctrl_b = ctrl_b;
    if (wr_b) begin
      next_ctrl_b.src = wbyte[ADCC_B_SRC_LSB +: 3];
      next_ctrl_b.vref = wbyte[ADCC_B_REF_LSB +: 2];
      next_ctrl_b.div = wbyte[ADCC_B_DIV_LSB +: 3];
    end
  end

  // Sequencer: a start while busy is ignored, power loss aborts
  always_comb begin
    next_state = state;
    unique case (state)
      ADCC_IDLE: begin
        if (start_kick) begin
          next_state = ADCC_CONV;
        end
      end
      ADCC_CONV: begin
        if (!next_power || conv_end) begin
          next_state = ADCC_IDLE;
        end
      end
    endcase
  end

  // Channel decode; reserved and parked codes open every switch
  genvar gi;
  generate
    for (gi = 0; gi < ADCC_NUM_CH; gi++) begin : g_ch
      if (gi == int'(ADCC_CH_RESERVED)) begin : g_hole
        assign next_mux.ext_ch[gi] = 1'b0;
      end else begin : g_sw
        assign next_mux.ext_ch[gi] = (next_ctrl_a.ch == 4'(gi));
      end
    end
  endgenerate

  // Internal sources; external codes close none of these
  assign next_mux.bandgap = (next_ctrl_b.src == ADCC_SRC_BANDGAP);
  assign next_mux.opamp = (next_ctrl_b.src == ADCC_SRC_OPAMP_A) |
                          (next_ctrl_b.src == ADCC_SRC_OPAMP_B);
  assign next_mux.vss = (next_ctrl_b.src == ADCC_SRC_VSS);
  // Reference: internal supply only on its one code
  assign next_mux.ref_vdd = (next_ctrl_b.vref == ADCC_REF_VDD);
  assign next_mux.ref_ext = ~next_mux.ref_vdd;

  // Read mux, using next values so a write just ahead is seen
  wire [31:0] rd_value = (haddr[7:0] == ADCC_OFF_CTRL_A) ? {24'h0, next_ctrl_a} :
                         (haddr[7:0] == ADCC_OFF_CTRL_B) ? {24'h0, next_ctrl_b} :
                         (haddr[7:0] == ADCC_OFF_RESULT) ? {16'h0, next_res_hi, next_res_lo} :
                         32'h0;

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      addr_q <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= addr_valid & hwrite;
      addr_q <= haddr[7:0];
      hrdata <= rd_take ? rd_value : 32'h0;
    end
  end

  // Control registers, all clear at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_a <= adcc_ctrl_a_t'(ADCC_CTRL_A_RESET);
      ctrl_b <= adcc_ctrl_b_t'(ADCC_CTRL_B_RESET);
    end else begin
      ctrl_a <= next_ctrl_a;
      ctrl_b <= next_ctrl_b;
    end
  end

  // Sequencer state and counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ADCC_IDLE;
      conv_cnt <= '0;
      div_cnt <= 7'h00;
    end else begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      if (start_kick || !in_conv) begin
        conv_cnt <= '0;
      end else if (conv_tick) begin
        conv_cnt <= conv_cnt + CNT_W'(1);
      end
    end
  end

  // Result synchroniser; converter holds its value at completion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_meta <= 12'h000;
      res_sync <= 12'h000;
      result <= 12'h000;
    end else begin
      res_meta <= result_in;
      res_sync <= res_meta;
      result <= next_result;
    end
  end

  // Registered outputs toward the analog side and pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Reset selection mirrors the cleared registers: channel 0, external reference
      mux_ctrl <= '{
        ext_ch: ADCC_NUM_CH'(1),
        bandgap: 1'b0,
        opamp: 1'b0,
        vss: 1'b0,
        ref_vdd: 1'b0,
        ref_ext: 1'b1
      };
      conv_power <= 1'b0;
      conv_clk_en <= 1'b0;
      conv_active <= 1'b0;
      pin_digital_off <= '0;
      pin_pullup_off <= '0;
      align_sel <= 1'b0;
      result_high <= 8'h00;
      result_low <= 8'h00;
      conv_done_evt <= 1'b0;
    end else begin
      mux_ctrl <= next_mux;
      conv_power <= next_ctrl_a.power;
      conv_clk_en <= next_tick & next_ctrl_a.power;
      conv_active <= (next_state == ADCC_CONV);
      pin_digital_off <= pin_analog_sel;
      pin_pullup_off <= pin_analog_sel;
      align_sel <= next_align;
      result_high <= next_res_hi;
      result_low <= next_res_lo;
      conv_done_evt <= conv_end;
    end
  end

  // Helper: cycles since last divider tick, and a divider change flag
  logic [7:0] gap_cnt;
  logic div_moved;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_cnt <= 8'h00;
      div_moved <= 1'b1;
    end else if (conv_tick || start_kick || !ctrl_a.power) begin
      gap_cnt <= 8'h01;
      div_moved <= start_kick | ~ctrl_a.power;
    end else begin
      gap_cnt <= gap_cnt + 8'h01;
      div_moved <= div_moved | (next_ctrl_b.div != ctrl_b.div);
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_kick;
    start_kick;
  endsequence
  sequence s_busy_held;
    ctrl_a.busy && conv_active;
  endsequence

  chk_start_sets_busy: assert property (s_kick |=> s_busy_held)
    else $error("busy not set after start sequence");
  chk_done_clears_busy: assert property (
    conv_done_evt |-> !ctrl_a.busy && $past(ctrl_a.busy))
    else $error("completion without busy clearing");
  chk_done_one_cycle: assert property (conv_done_evt |=> !conv_done_evt)
    else $error("completion pulse longer than one cycle");
  chk_power_gates_busy: assert property (!conv_power |-> !ctrl_a.busy)
    else $error("busy while converter unpowered");
  chk_reserved_open: assert property (
    (ctrl_a.ch == ADCC_CH_RESERVED || ctrl_a.ch > ADCC_CH_LAST)
      |-> mux_ctrl.ext_ch == '0)
    else $error("reserved channel code closed a switch");
  chk_channel_single: assert property (
    $onehot0(mux_ctrl.ext_ch) and (ctrl_a.ch <= ADCC_CH_LAST &&
      ctrl_a.ch != ADCC_CH_RESERVED |-> mux_ctrl.ext_ch[ctrl_a.ch]))
    else $error("channel switch does not match field");
  chk_source_ext: assert property (
    (ctrl_b.src == ADCC_SRC_EXT || ctrl_b.src > ADCC_SRC_VSS)
      |-> !mux_ctrl.bandgap && !mux_ctrl.opamp && !mux_ctrl.vss)
    else $error("internal source closed on external code");
  chk_source_int: assert property (
    $onehot0({mux_ctrl.bandgap, mux_ctrl.opamp, mux_ctrl.vss}) and
    (ctrl_b.src == ADCC_SRC_BANDGAP |-> mux_ctrl.bandgap) and
    (ctrl_b.src == ADCC_SRC_VSS |-> mux_ctrl.vss) and
    (ctrl_b.src[2:1] == 2'b01 |-> mux_ctrl.opamp))
    else $error("internal source switch wrong");
  chk_reference_sel: assert property (
    (ctrl_b.vref == ADCC_REF_VDD) == mux_ctrl.ref_vdd &&
      mux_ctrl.ref_ext == !mux_ctrl.ref_vdd)
    else $error("reference select wrong");
  chk_divider_rate: assert property (
    conv_tick && !div_moved |-> gap_cnt == {1'b0, div_last(ctrl_b.div)} + 8'h01)
    else $error("conversion clock period wrong");
  chk_pin_release: assert property (
    pin_analog_sel[0] ##1 pin_analog_sel[0] |-> pin_digital_off[0] && pin_pullup_off[0])
    else $error("analog pin kept digital function or pull-up");
  chk_result_align: assert property (
    (!align_sel |-> result_low[3:0] == 4'h0) and (align_sel |-> result_high[7:4] == 4'h0))
    else $error("result alignment padding wrong");
  // Result holds between completions, even with the converter off
  chk_result_held: assert property (!conv_end |=> $stable(result))
    else $error("result changed without completion");
  // No conversion clock pulse reaches an unpowered converter
  chk_clock_gated: assert property (!conv_power |-> !conv_clk_en)
    else $error("conversion clock while unpowered");
  // Busy status and the sequencer output agree
  chk_busy_mirror: assert property (conv_active == ctrl_a.busy)
    else $error("busy flag and active output disagree");
  // Power loss during a conversion ends it with no completion pulse
  chk_abort_silent: assert property (in_conv && !next_power |=> !conv_done_evt)
    else $error("completion pulse after power loss");

endmodule : adcc_top

// >>> hdl/adcc_pkg.sv
// Constants, field layouts and carrier types for the converter control block
package adcc_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] ADCC_OFF_CTRL_A = 8'h00;
  localparam logic [7:0] ADCC_OFF_CTRL_B = 8'h04;
  localparam logic [7:0] ADCC_OFF_RESULT = 8'h08;

  // Reset values of the two control registers
  localparam logic [7:0] ADCC_CTRL_A_RESET = 8'h00;
  localparam logic [7:0] ADCC_CTRL_B_RESET = 8'h00;

  // Field positions in control register A
  localparam int ADCC_A_START_BIT = 7;
  localparam int ADCC_A_BUSY_BIT = 6;
  localparam int ADCC_A_POWER_BIT = 5;
  localparam int ADCC_A_ALIGN_BIT = 4;
  localparam int ADCC_A_CH_LSB = 0;

  // Field positions in control register B
  localparam int ADCC_B_SRC_LSB = 5;
  localparam int ADCC_B_REF_LSB = 3;
  localparam int ADCC_B_DIV_LSB = 0;

  // Input source codes
  localparam logic [2:0] ADCC_SRC_EXT = 3'h0;
  localparam logic [2:0] ADCC_SRC_BANDGAP = 3'h1;
  localparam logic [2:0] ADCC_SRC_OPAMP_A = 3'h2;
  localparam logic [2:0] ADCC_SRC_OPAMP_B = 3'h3;
  localparam logic [2:0] ADCC_SRC_VSS = 3'h4;

  // Reference select code for the internal supply
  localparam logic [1:0] ADCC_REF_VDD = 2'h1;

  // Channel codes: one reserved hole, last usable code
  localparam logic [3:0] ADCC_CH_RESERVED = 4'h7;
  localparam logic [3:0] ADCC_CH_LAST = 4'h9;
  localparam int ADCC_NUM_CH = 10;

  // Conversion length in conversion clock ticks
  localparam int ADCC_CONV_CLOCKS = 16;

  // Control register A layout
  typedef struct packed {
    logic start;
    logic busy;
    logic power;
    logic align;
    logic [3:0] ch;
  } adcc_ctrl_a_t;

  // Control register B layout
  typedef struct packed {
    logic [2:0] src;
    logic [1:0] vref;
    logic [2:0] div;
  } adcc_ctrl_b_t;

  // Analog switch controls toward the input selector
  typedef struct packed {
    logic [ADCC_NUM_CH-1:0] ext_ch;
    logic bandgap;
    logic opamp;
    logic vss;
    logic ref_vdd;
    logic ref_ext;
  } adcc_mux_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b01,
    ADCC_CONV = 2'b10
  } adcc_state_t;

endpackage : adcc_pkg

// >>> test/adcc_analog_model.sv
// Behavioural model of the input selector and converter on the far side
`timescale 1ns/10ps
module adcc_analog_model
  import adcc_pkg::*;
(
  input wire logic hclk,
  input wire adcc_mux_t mux_ctrl,
  input wire logic conv_power,
  output logic [11:0] result_in
);
  // Level of the one source that reaches the single converter
  logic [11:0] level;
  // Toggles every cycle so an unpowered converter never holds a value
  logic flip = 1'b0;
  // Bandgap gives its own level, everything else a second level
  assign level = mux_ctrl.bandgap ? 12'h5A3 : 12'hC3A;
  // Flip the idle pattern every cycle
  always @(posedge hclk) begin
    flip <= ~flip;
  end
  // Result only means something while the converter is powered
  assign result_in = conv_power ? level : {12{flip}};
endmodule : adcc_analog_model

// >>> test/adc_control_registers_tb.sv
// Self-checking bench for the converter control registers
`timescale 1ns/10ps
module adc_control_registers_tb
  import adcc_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] result_in;
  logic [9:0] pin_analog_sel, pin_digital_off, pin_pullup_off;
  adcc_mux_t mux_ctrl;
  logic conv_power, conv_clk_en, conv_active, align_sel, conv_done_evt;
  logic [7:0] result_high, result_low;
  int num_errors = 0;
  int n_compared = 0;
  // The single slave drives the bus ready
  assign hready = hreadyout;
  // Short conversion keeps the run brief
  adcc_top #(.CONV_CLOCKS(2)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .result_in(result_in), .pin_analog_sel(pin_analog_sel), .mux_ctrl(mux_ctrl),
    .conv_power(conv_power), .conv_clk_en(conv_clk_en), .conv_active(conv_active),
    .pin_digital_off(pin_digital_off), .pin_pullup_off(pin_pullup_off),
    .align_sel(align_sel), .result_high(result_high), .result_low(result_low),
    .conv_done_evt(conv_done_evt));
  adcc_analog_model model (.hclk(hclk), .mux_ctrl(mux_ctrl), .conv_power(conv_power),
    .result_in(result_in));
  // 25 MHz clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One single AHB transfer, then one idle edge so outputs settle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 64) begin
      @(posedge hclk);
      n++;
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    @(posedge hclk);
    while (hready !== 1'b1 && n < 64) begin
      @(posedge hclk);
      n++;
    end
    r = hrdata;
    check("resp", 32'(hresp), 32'h00000000);
    if (n >= 64) num_errors++;
    @(posedge hclk);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 8'h00, r);
    check($sformatf("register %h", a), r, e);
  endtask : rd_chk
  // Edges until the next conversion clock pulse is seen
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (conv_clk_en !== 1'b1 && n < 300);
  endtask : wait_tick
  task automatic test_reset;
    check("mux", 32'(mux_ctrl), 32'h00000021);
    check("power", 32'(conv_power), 32'h00000000);
    rd_chk(8'h00, 32'h00000000);
    rd_chk(8'h04, 32'h00000000);
    $display("test reset done");
  endtask : test_reset
  task automatic test_regs;
    wr(8'h04, 8'hFF);
    rd_chk(8'h04, 32'h000000FF);
    wr(8'h00, 8'h5F);
    rd_chk(8'h00, 32'h0000001F);
    wr(8'h0C, 8'hFF);
    rd_chk(8'h0C, 32'h00000000);
    rd_chk(8'h08, 32'h00000000);
    $display("test registers done");
  endtask : test_regs
  task automatic test_select;
    logic [4:0] f;
    logic [9:0] e;
    wr(8'h00, 8'h03);
    for (int s = 0; s < 8; s++) begin
      for (int v = 0; v < 4; v++) begin
        wr(8'h04, {s[2:0], v[1:0], 3'h0});
        f = {s == 1, s == 2 || s == 3, s == 4, v == 1, v != 1};
        check("mux", 32'(mux_ctrl), {17'h00000, 10'h008, f});
      end
    end
    wr(8'h04, 8'h00);
    for (int c = 0; c < 16; c++) begin
      wr(8'h00, 8'(c));
      e = (c < 10 && c != 7) ? 10'(1 << c) : 10'h000;
      check("channel", 32'(mux_ctrl.ext_ch), 32'(e));
    end
    $display("test selection done");
  endtask : test_select
  task automatic test_pins;
    pin_analog_sel <= 10'h2A5;
    repeat (2) @(posedge hclk);
    check("digital off", 32'(pin_digital_off), 32'h000002A5);
    check("pullup off", 32'(pin_pullup_off), 32'h000002A5);
    pin_analog_sel <= 10'h000;
    $display("test pins done");
  endtask : test_pins
  task automatic test_divider;
    int n;
    wr(8'h00, 8'h20);
    for (int d = 0; d < 8; d++) begin
      wr(8'h04, 8'(d));
      wait_tick(n);
      wait_tick(n);
      wait_tick(n);
      check("tick spacing", 32'(n), 32'(1 << d));
    end
    $display("test divider done");
  endtask : test_divider
  task automatic test_convert;
    logic [11:0] v;
    logic [7:0] a;
    int n;
    for (int al = 0; al < 2; al++) begin
      v = al ? 12'h5A3 : 12'hC3A;
      // Internal source parks the channel on a code above the last channel
      a = al ? 8'h3A : 8'h20;
      wr(8'h04, al ? 8'h23 : 8'h03);
      wr(8'h00, a | 8'h80);
      wr(8'h00, a);
      rd_chk(8'h00, 32'(a | 8'h40));
      check("align", 32'(align_sel), 32'(al));
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (conv_done_evt !== 1'b1 && n < 1000);
      check("busy at done", 32'(conv_active), 32'h00000000);
      check("high", 32'(result_high), al ? 32'(v[11:8]) : 32'(v[11:4]));
      check("low", 32'(result_low), al ? 32'(v[7:0]) : 32'({v[3:0], 4'h0}));
      @(posedge hclk);
      check("done width", 32'(conv_done_evt), 32'h00000000);
      rd_chk(8'h00, 32'(a));
      rd_chk(8'h08, al ? 32'(v) : 32'({v, 4'h0}));
    end
    $display("test conversion done");
  endtask : test_convert
  task automatic test_abort;
    int seen;
    wr(8'h00, 8'h80);
    wr(8'h00, 8'h00);
    rd_chk(8'h00, 32'h00000000);
    wr(8'h00, 8'hA0);
    wr(8'h00, 8'h20);
    check("power", 32'(conv_power), 32'h00000001);
    wr(8'h00, 8'h00);
    check("power", 32'(conv_power), 32'h00000000);
    seen = 0;
    repeat (300) begin
      @(posedge hclk);
      if (conv_done_evt === 1'b1) seen = 1;
    end
    check("abort done", 32'(seen), 32'h00000000);
    rd_chk(8'h00, 32'h00000000);
    $display("test abort done");
  endtask : test_abort
  // Single closing point of the run
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    pin_analog_sel = 10'h000;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_reset;
    test_regs;
    test_select;
    test_pins;
    test_divider;
    test_convert;
    test_abort;
    print_verdict;
  end
  // Hang guard, well past the expected length of the run
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    print_verdict;
  end
endmodule : adc_control_registers_tb
